// File: design/line_scan_gate_controller.sv
// Line-scan acquisition gate controller: gates camera lines into host buffers.
// Assumes the camera stream, commands and configuration share clk; the two
// hardware event lines come from pins and are synchronised here.
//
// Summary of operation
// R1 - Immediate source opens at next line boundary.
// R2 - End call closes gate in continuous scanning.
// R3 - Full buffers and final partial buffer released.
// R4 - Fixed length uses positive lines per scan.
// R5 - Begin call arms start trigger, then waits.
// R6 - Start from command or selected hardware line.
// R7 - Start events ignored while scanning.
// R8 - Gate opens at boundary after start event.
// R9 - Fixed length closes on count or call.
// R10 - Scan end releases buffer; next starts fresh.
// R11 - Variable length closes at boundary after event.
// R12 - End from halt command or selected line.
// R13 - End events ignored while not scanning.
// R14 - Buffers hold whole lines only.
// R15 - Line not fitting starts a new buffer.
// R16 - Boundaries lie between complete camera lines.
`timescale 1ns/1ps
`default_nettype none

module line_scan_gate_controller (
  input wire logic clk,
  input wire logic rst_n,
  // Camera line stream.
  input wire logic cam_valid,
  output logic cam_ready,
  input wire logic [lsg_pkg::DATA_W-1:0] cam_data,
  input wire logic cam_eol,
  // Configuration.
  input wire logic [1:0] scan_begin_source,
  input wire logic [1:0] scan_end_source,
  input wire logic [lsg_pkg::CNT_W-1:0] lines_per_scan,
  input wire logic [lsg_pkg::CNT_W-1:0] line_words,
  input wire logic [lsg_pkg::CNT_W-1:0] buffer_words,
  // Software commands, one-cycle pulses.
  input wire logic acquisition_begin_call,
  input wire logic acquisition_end_call,
  input wire logic begin_scan_command,
  input wire logic halt_scan_command,
  // Hardware event pins.
  input wire logic line_input_one,
  input wire logic line_input_two,
  // Stream toward the host buffers.
  output logic dma_valid,
  input wire logic dma_ready,
  output logic [lsg_pkg::DATA_W-1:0] dma_data,
  output logic dma_buf_end,
  // Status.
  output logic gate_open,
  output logic acquisition_active,
  output logic scan_armed
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  lsg_pkg::gate_state_t state_ff;
  lsg_pkg::gate_state_t nxt_state;
  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] pin_prev_ff;
  logic [1:0] pin_rise;
  logic acq_active_ff;
  logic in_line_ff;
  logic cap_line_ff;
  logic end_req_ff;
  logic hold_valid_ff;
  logic [lsg_pkg::DATA_W-1:0] hold_data_ff;
  logic [lsg_pkg::CNT_W-1:0] used_ff;
  logic [lsg_pkg::CNT_W-1:0] lines_done_ff;
  logic [lsg_pkg::CNT_W:0] used_plus_line;
  logic [lsg_pkg::CNT_W:0] lines_next;
  logic cap_ok;
  logic cap_word;
  logic word_acc;
  logic cap_acc;
  logic sol;
  logic split;
  logic start_evt;
  logic end_evt;
  logic count_hit;
  logic flush_done;
  logic rearm;
  logic push_hold;
  logic fifo_in_ready;
  logic [lsg_pkg::DATA_W:0] fifo_in_data;
  logic [lsg_pkg::DATA_W:0] fifo_out_data;

  // ---------------------------------------------------------------------------
  // Hardware event synchronisers
  // ---------------------------------------------------------------------------
  // Three flops per pin; the second and third flops feed the edge detector.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= lsg_pkg::SYNC_RESET;
      pin_sync_ff <= lsg_pkg::SYNC_RESET;
      pin_prev_ff <= lsg_pkg::SYNC_RESET;
    end else begin
      pin_meta_ff <= {line_input_two, line_input_one};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // A rising edge on a pin is one event.
  assign pin_rise = pin_sync_ff & ~pin_prev_ff;

  // ---------------------------------------------------------------------------
  // Trigger qualification
  // ---------------------------------------------------------------------------
  // Start events count only while armed; anything else drops them.
  always_comb begin
    start_evt = 1'b0;
    if (state_ff == lsg_pkg::st_armed) begin // [R7]
      start_evt = begin_scan_command; // [R6]
      if (scan_begin_source == lsg_pkg::BEGIN_SRC_LINE_ONE) begin
        start_evt = start_evt || pin_rise[0]; // [R6]
      end else if (scan_begin_source == lsg_pkg::BEGIN_SRC_LINE_TWO) begin
        start_evt = start_evt || pin_rise[1]; // [R6]
      end
    end
  end

  // End events count only during a scan; in count mode only the count or the end call ends it.
  always_comb begin
    end_evt = 1'b0;
    if (state_ff == lsg_pkg::st_scan) begin // [R13]
      if (scan_end_source == lsg_pkg::END_SRC_COMMAND) begin
        end_evt = halt_scan_command; // [R12]
      end else if (scan_end_source == lsg_pkg::END_SRC_LINE_TWO) begin
        end_evt = halt_scan_command || pin_rise[1]; // [R12]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Line framing and gating
  // ---------------------------------------------------------------------------
  // A new line may be captured only while scanning and no close is pending,
  // so a line starting right after the closing boundary is never taken.
  assign cap_ok = (state_ff == lsg_pkg::st_scan) && !end_req_ff; // [R16]
  assign cap_word = in_line_ff ? cap_line_ff : cap_ok;
  // Dropped words are always taken so the camera never stalls outside a scan.
  assign cam_ready = cap_word ? (fifo_in_ready || !hold_valid_ff) : 1'b1;
  assign word_acc = cam_valid && cam_ready;
  assign cap_acc = word_acc && cap_word;
  assign sol = word_acc && !in_line_ff;

  // Line tracking: the gate decision is latched at the first word of a line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_line_ff <= 1'b0;
      cap_line_ff <= 1'b0;
    end else if (word_acc) begin
      in_line_ff <= !cam_eol;
      if (sol) begin
        cap_line_ff <= cap_ok; // [R16]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Buffer packing
  // ---------------------------------------------------------------------------
  // A line that would not fit in what is left starts a new buffer; the flag
  // goes on the held last word of the previous line, never inside a line.
  assign used_plus_line = {1'b0, used_ff} + {1'b0, line_words};
  assign split = cap_acc && sol && (used_ff != lsg_pkg::CNT_RESET) &&
                 (used_plus_line > {1'b0, buffer_words}); // [R15]

  // The hold stage keeps the newest word so a scan end can mark it last.
  assign push_hold = hold_valid_ff && (cap_acc || (state_ff == lsg_pkg::st_flush));
  assign fifo_in_data = {(state_ff == lsg_pkg::st_flush) || split, hold_data_ff}; // [R3]
  assign flush_done = !hold_valid_ff || fifo_in_ready;

  // Hold register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_valid_ff <= 1'b0;
      hold_data_ff <= lsg_pkg::DATA_RESET;
    end else if (cap_acc) begin
      hold_valid_ff <= 1'b1; // [R14]
      hold_data_ff <= cam_data;
    end else if ((state_ff == lsg_pkg::st_flush) && fifo_in_ready) begin
      hold_valid_ff <= 1'b0; // [R10]
    end
  end

  // Words written into the current buffer; a scan end restarts at zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      used_ff <= lsg_pkg::CNT_RESET;
    end else if (state_ff == lsg_pkg::st_flush) begin
      used_ff <= lsg_pkg::CNT_RESET; // [R10]
    end else if (cap_acc) begin
      if (split) begin
        used_ff <= 16'h0001; // [R15]
      end else begin
        used_ff <= used_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Line counting
  // ---------------------------------------------------------------------------
  // A zero count acts as one, since at least one line is always taken.
  assign lines_next = {1'b0, lines_done_ff} + 17'h00001;
  assign count_hit = cap_acc && cam_eol && (state_ff == lsg_pkg::st_scan) &&
                     (scan_end_source == lsg_pkg::END_SRC_COUNT) &&
                     (lines_next >= {1'b0, lines_per_scan}); // [R4]

  // Captured lines in the current scan.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lines_done_ff <= lsg_pkg::CNT_RESET;
    end else if (state_ff != lsg_pkg::st_scan) begin
      lines_done_ff <= lsg_pkg::CNT_RESET;
    end else if (cap_acc && cam_eol) begin
      lines_done_ff <= lines_next[lsg_pkg::CNT_W-1:0];
    end
  end

  // Pending close request; taken at the next point between lines.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_req_ff <= 1'b0;
    end else if (state_ff != lsg_pkg::st_scan) begin
      end_req_ff <= 1'b0;
    end else if (acquisition_end_call) begin
      end_req_ff <= 1'b1; // [R2] [R9]
    end else if (end_evt) begin
      end_req_ff <= 1'b1; // [R11]
    end else if (count_hit) begin
      end_req_ff <= 1'b1; // [R9]
    end
  end

  // ---------------------------------------------------------------------------
  // Acquisition activity
  // ---------------------------------------------------------------------------
  // Begin is honoured only when idle; end always wins over begin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_active_ff <= 1'b0;
    end else if (acquisition_end_call) begin
      acq_active_ff <= 1'b0;
    end else if (acquisition_begin_call && (state_ff == lsg_pkg::st_idle)) begin
      acq_active_ff <= 1'b1;
    end
  end

  // Triggered modes re-arm after each object; immediate mode stops.
  assign rearm = acq_active_ff && !acquisition_end_call &&
                 (scan_begin_source != lsg_pkg::BEGIN_SRC_IMMEDIATE); // [R5]

  // ---------------------------------------------------------------------------
  // Gate state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lsg_pkg::st_idle: begin
        if (acquisition_begin_call && !acquisition_end_call) begin
          if (scan_begin_source == lsg_pkg::BEGIN_SRC_IMMEDIATE) begin
            nxt_state = lsg_pkg::st_pending; // [R1]
          end else begin
            nxt_state = lsg_pkg::st_armed; // [R5]
          end
        end
      end
      lsg_pkg::st_armed: begin
        if (acquisition_end_call) begin
          nxt_state = lsg_pkg::st_idle;
        end else if (start_evt) begin
          nxt_state = lsg_pkg::st_pending; // [R5]
        end
      end
      lsg_pkg::st_pending: begin
        // Opening waits until the camera is between lines.
        if (acquisition_end_call) begin
          nxt_state = lsg_pkg::st_idle;
        end else if (!in_line_ff) begin
          nxt_state = lsg_pkg::st_scan; // [R8] [R1]
        end
      end
      lsg_pkg::st_scan: begin
        if (end_req_ff && !in_line_ff) begin
          nxt_state = lsg_pkg::st_flush; // [R11] [R9]
        end
      end
      lsg_pkg::st_flush: begin
        if (flush_done) begin
          nxt_state = rearm ? lsg_pkg::st_armed : lsg_pkg::st_idle; // [R10]
        end
      end
      default: begin
        nxt_state = lsg_pkg::st_idle;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= lsg_pkg::st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Output buffering
  // ---------------------------------------------------------------------------
  // The FIFO absorbs host stalls; when it fills, cam_ready drops mid-scan.
  word_fifo #(
    .WIDTH(lsg_pkg::DATA_W + 1),
    .DEPTH(lsg_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_hold),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(dma_valid),
    .out_ready(dma_ready),
    .out_data(fifo_out_data)
  );

  // Bit above the data marks the last word of a buffer.
  assign dma_data = fifo_out_data[lsg_pkg::DATA_W-1:0];
  assign dma_buf_end = fifo_out_data[lsg_pkg::DATA_W]; // [R3]

  // ---------------------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------------------
  assign gate_open = (state_ff == lsg_pkg::st_scan);
  assign acquisition_active = acq_active_ff;
  assign scan_armed = (state_ff == lsg_pkg::st_armed);

endmodule : line_scan_gate_controller

`default_nettype wire

// File: include/lsg_pkg.sv
// Shared constants and types for the line-scan acquisition gate controller.
// Assumes every file that needs them refers to them as lsg_pkg::name.
package lsg_pkg;

  // ---------------------------------------------------------------------------
  // Data path widths and buffering
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------------------
  // Start-of-scan source codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] BEGIN_SRC_IMMEDIATE = 2'h0;
  localparam logic [1:0] BEGIN_SRC_COMMAND = 2'h1;
  localparam logic [1:0] BEGIN_SRC_LINE_ONE = 2'h2;
  localparam logic [1:0] BEGIN_SRC_LINE_TWO = 2'h3;

  // ---------------------------------------------------------------------------
  // End-of-scan source codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] END_SRC_COMMAND = 2'h0;
  localparam logic [1:0] END_SRC_LINE_TWO = 2'h1;
  localparam logic [1:0] END_SRC_COUNT = 2'h2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Gate controller states.
  typedef enum logic [2:0] {
    st_idle,
    st_armed,
    st_pending,
    st_scan,
    st_flush
  } gate_state_t;

endpackage : lsg_pkg

// File: design/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic do_wr;
  logic do_rd;

  // ---------------------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------------------
  // Full and empty come from the occupancy count, so they never lie.
  assign in_ready = (count_ff != DEPTH[PTR_W:0]);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Storage array; written only, never reset, since count guards reads.
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : word_fifo

`default_nettype wire

// File: sim/line_scan_gate_assertions.sv
// Port-level checks of the gate controller.
// Assumes lines of a few words, so each open or close falls within 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module line_scan_gate_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cam_valid,
  input wire logic cam_ready,
  input wire logic cam_eol,
  input wire logic [1:0] scan_begin_source,
  input wire logic [1:0] scan_end_source,
  input wire logic [lsg_pkg::CNT_W-1:0] lines_per_scan,
  input wire logic acquisition_begin_call,
  input wire logic acquisition_end_call,
  input wire logic begin_scan_command,
  input wire logic halt_scan_command,
  input wire logic line_input_two,
  input wire logic gate_open,
  input wire logic acquisition_active,
  input wire logic scan_armed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [lsg_pkg::CNT_W-1:0] lines_ff;
  // Lines ended while open; cleared when closed so each scan counts afresh.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lines_ff <= lsg_pkg::CNT_RESET;
    end else if (!gate_open) begin
      lines_ff <= lsg_pkg::CNT_RESET;
    end else if (cam_valid && cam_ready && cam_eol) begin
      lines_ff <= lines_ff + 16'h0001;
    end
  end
  sequence s_idle_call;
    acquisition_begin_call && !acquisition_active && !acquisition_end_call && !gate_open && !$past(gate_open);
  endsequence
  sequence s_close_soon;
    ##[1:40] !gate_open;
  endsequence
  drop_when_closed_a: assert property (!gate_open |-> cam_ready)
    else $error("closed gate stalled the camera");
  armed_not_open_a: assert property (($rose(scan_armed) && scan_begin_source == 2'h1 && !begin_scan_command)
    ##1 !begin_scan_command |=> !gate_open)
    else $error("stale start event opened the gate");
  arm_on_call_a: assert property (s_idle_call ##0 scan_begin_source != 2'h0 |=> scan_armed)
    else $error("begin call did not arm");
  immediate_open_a: assert property (s_idle_call ##0 scan_begin_source == 2'h0 |-> ##[2:40] gate_open)
    else $error("immediate start did not open");
  open_after_start_a: assert property (begin_scan_command && scan_armed
    && !acquisition_end_call |-> ##[1:40] gate_open)
    else $error("start command did not open");
  end_call_close_a: assert property (acquisition_end_call && gate_open |-> s_close_soon)
    else $error("end call did not close");
  halt_close_a: assert property (halt_scan_command && gate_open && scan_end_source < 2'h2 |-> s_close_soon)
    else $error("halt command did not close");
  pin_close_a: assert property ($rose(line_input_two) && gate_open && scan_end_source == 2'h1 |-> ##[1:44] !gate_open)
    else $error("end pin did not close");
  halt_idle_a: assert property (halt_scan_command && scan_armed && !begin_scan_command
    && !acquisition_end_call && scan_begin_source == 2'h1 |=> scan_armed)
    else $error("halt outside a scan was acted on");
  count_cap_a: assert property (gate_open && scan_end_source == 2'h2
    && lines_per_scan != 16'h0000 |-> lines_ff <= lines_per_scan)
    else $error("scan ran past its line count");
  count_close_a: assert property (gate_open && scan_end_source == 2'h2 && lines_per_scan != 16'h0000
    && lines_ff == lines_per_scan |-> ##[1:4] !gate_open)
    else $error("count reached but gate stayed open");
endmodule : line_scan_gate_assertions
bind line_scan_gate_controller line_scan_gate_assertions u_chk (.clk(clk), .rst_n(rst_n), .cam_valid(cam_valid),
  .cam_ready(cam_ready), .cam_eol(cam_eol), .scan_begin_source(scan_begin_source),
  .scan_end_source(scan_end_source), .lines_per_scan(lines_per_scan),
  .acquisition_begin_call(acquisition_begin_call), .acquisition_end_call(acquisition_end_call),
  .begin_scan_command(begin_scan_command), .halt_scan_command(halt_scan_command),
  .line_input_two(line_input_two), .gate_open(gate_open), .acquisition_active(acquisition_active),
  .scan_armed(scan_armed));
`default_nettype wire

// File: sim/line_camera_model.sv
// Behavioural line-scan camera: lines of fixed word count with gaps between.
// Assumes the camera shares clk; word data is {line number, word index}.
`timescale 1ns/1ps
`default_nettype none
module line_camera_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic slow,
  input wire logic cam_ready,
  input wire logic [15:0] words,
  output logic cam_valid,
  output logic [31:0] cam_data,
  output logic cam_eol
);
  logic [15:0] idx_ff;
  logic [15:0] line_ff;
  logic [1:0] gap_ff;
  // Idle data is inverted so stale words cannot pass for fresh ones.
  assign cam_data = cam_valid ? {line_ff, idx_ff} : ~{line_ff, idx_ff};
  assign cam_eol = cam_valid && (idx_ff == words - 16'h0001);
  // A word is held until taken; the slow setting widens the gap between lines.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cam_valid <= 1'b0;
      idx_ff <= 16'h0000;
      line_ff <= 16'h0000;
      gap_ff <= 2'h0;
    end else if (cam_valid && cam_ready) begin
      idx_ff <= cam_eol ? 16'h0000 : idx_ff + 16'h0001;
      if (cam_eol) begin
        cam_valid <= 1'b0;
        line_ff <= line_ff + 16'h0001;
        gap_ff <= slow ? 2'h3 : 2'h1;
      end
    end else if (!cam_valid) begin
      if (gap_ff != 2'h0) gap_ff <= gap_ff - 2'h1;
      else cam_valid <= run;
    end
  end
endmodule : line_camera_model
`default_nettype wire

// File: sim/line_scan_gate_controller_bench.sv
// Self-checking bench for the gate controller with a camera model.
// Assumes lines of 4 words and buffers of 10 words, so two lines fill a buffer.
`timescale 1ns/1ps
`default_nettype none
module line_scan_gate_controller_bench;
  localparam logic [15:0] LW = 16'h0004;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cam_valid, cam_ready, cam_eol, dma_valid, dma_buf_end, gate_open, acquisition_active, scan_armed;
  logic [31:0] cam_data, dma_data;
  logic [1:0] scan_begin_source = 2'h0;
  logic [1:0] scan_end_source = 2'h0;
  logic [15:0] lines_per_scan = 16'h0005;
  logic [15:0] line_words = LW;
  logic [15:0] buffer_words = 16'h000a;
  logic acquisition_begin_call = 1'b0, acquisition_end_call = 1'b0;
  logic begin_scan_command = 1'b0, halt_scan_command = 1'b0;
  logic line_input_one = 1'b0, line_input_two = 1'b0, dma_ready = 1'b1, slow = 1'b0;
  logic [15:0] widx = 16'h0000;
  int fail_count = 0, comparisons = 0, words = 0, ends = 0, cycles = 0;
  always #10 clk = ~clk;
  line_camera_model u_cam (.clk(clk), .rst_n(rst_n), .run(1'b1), .slow(slow), .cam_ready(cam_ready),
    .words(line_words), .cam_valid(cam_valid), .cam_data(cam_data), .cam_eol(cam_eol));
  line_scan_gate_controller u_dut (.clk(clk), .rst_n(rst_n), .cam_valid(cam_valid), .cam_ready(cam_ready),
    .cam_data(cam_data), .cam_eol(cam_eol), .scan_begin_source(scan_begin_source),
    .scan_end_source(scan_end_source), .lines_per_scan(lines_per_scan), .line_words(line_words),
    .buffer_words(buffer_words), .acquisition_begin_call(acquisition_begin_call),
    .acquisition_end_call(acquisition_end_call), .begin_scan_command(begin_scan_command),
    .halt_scan_command(halt_scan_command), .line_input_one(line_input_one), .line_input_two(line_input_two),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data), .dma_buf_end(dma_buf_end),
    .gate_open(gate_open), .acquisition_active(acquisition_active), .scan_armed(scan_armed));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // One-cycle pulse: 0 begin call, 1 end call, 2 start command, 3 halt command.
  task automatic pulse(input int k);
    {acquisition_begin_call, acquisition_end_call, begin_scan_command, halt_scan_command} = 4'h8 >> k;
    step(1);
    {acquisition_begin_call, acquisition_end_call, begin_scan_command, halt_scan_command} = 4'h0;
    step(1);
  endtask : pulse
  task automatic wait_gate(input logic v);
    for (int i = 0; i < 200 && gate_open !== v; i++) step(1);
    check(gate_open, v);
  endtask : wait_gate
  task automatic drain;
    step(3);
    for (int i = 0; i < 100 && dma_valid !== 1'b0; i++) step(1);
  endtask : drain
  // Monitor of the host side; counts words and buffer ends, word index must run whole lines.
  always @(posedge clk) begin
    if (rst_n && dma_valid && dma_ready) begin
      check(dma_data[15:0], widx);
      if (dma_buf_end) begin
        ends++;
        check(widx, LW - 16'h0001);
      end
      words++;
      widx = (widx == LW - 16'h0001) ? 16'h0000 : widx + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_count;
    scan_begin_source = lsg_pkg::BEGIN_SRC_COMMAND;
    scan_end_source = lsg_pkg::END_SRC_COUNT;
    words = 0;
    ends = 0;
    pulse(0);
    check(scan_armed, 1'b1);
    pulse(3);
    step(4);
    check(gate_open, 1'b0);
    dma_ready = 1'b0;
    pulse(2);
    wait_gate(1'b1);
    pulse(2);
    for (int i = 0; i < 60 && cam_ready !== 1'b0; i++) step(1);
    check(cam_ready, 1'b0);
    dma_ready = 1'b1;
    wait_gate(1'b0);
    drain;
    check(words, 20);
    check(ends, 3);
    check(scan_armed, 1'b1);
    lines_per_scan = 16'h0064;
    words = 0;
    ends = 0;
    pulse(2);
    wait_gate(1'b1);
    step(12);
    pulse(1);
    wait_gate(1'b0);
    drain;
    check(ends, (words / 4 + 1) / 2);
    check(acquisition_active, 1'b0);
    $display("test count mode done");
  endtask : t_count
  task automatic t_continuous;
    scan_begin_source = lsg_pkg::BEGIN_SRC_IMMEDIATE;
    scan_end_source = lsg_pkg::END_SRC_COMMAND;
    slow = 1'b1;
    words = 0;
    ends = 0;
    pulse(0);
    wait_gate(1'b1);
    step(30);
    pulse(1);
    wait_gate(1'b0);
    drain;
    check(words % 4, 0);
    check(ends, (words / 4 + 1) / 2);
    check(scan_armed, 1'b0);
    slow = 1'b0;
    $display("test continuous done");
  endtask : t_continuous
  task automatic t_pins;
    scan_begin_source = lsg_pkg::BEGIN_SRC_LINE_ONE;
    scan_end_source = lsg_pkg::END_SRC_LINE_TWO;
    words = 0;
    pulse(0);
    line_input_two = 1'b1;
    step(6);
    check(scan_armed, 1'b1);
    line_input_two = 1'b0;
    line_input_one = 1'b1;
    wait_gate(1'b1);
    line_input_one = 1'b0;
    step(10);
    line_input_two = 1'b1;
    wait_gate(1'b0);
    line_input_two = 1'b0;
    step(1);
    check(scan_armed, 1'b1);
    pulse(2);
    wait_gate(1'b1);
    step(6);
    pulse(3);
    wait_gate(1'b0);
    step(1);
    scan_begin_source = lsg_pkg::BEGIN_SRC_LINE_TWO;
    line_input_two = 1'b1;
    wait_gate(1'b1);
    line_input_two = 1'b0;
    pulse(3);
    wait_gate(1'b0);
    step(1);
    pulse(1);
    check(scan_armed, 1'b0);
    drain;
    check(words % 4, 0);
    $display("test event pins done");
  endtask : t_pins
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    step(6);
    rst_n = 1'b1;
    step(1);
    t_count;
    t_continuous;
    t_pins;
    tally_and_finish;
  end
endmodule : line_scan_gate_controller_bench
`default_nettype wire
